// file: sdw_port.sv
// Serial display write port: pin sampling, byte assembly and command decoding.
//
// Function
// - Traffic accepted only while chip select low.
// - Select low marks command, high marks data.
// - One data bit per serial clock rise.
// - Every transfer unit is eight bits.
// - Bytes arrive most significant bit first.
// - Sample on first edge after idle.
// - Pixel colour is 16-bit 5-6-5 value.
// - Cursor steps rows and columns per scan.
// - Array up to 240 by 320 pixels.
// - Backlight lit while its input is high.
`include "sdw_defines.svh"
`default_nettype none
module sdw_port
   import sdw_pkg::*;
(
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic chip_select_low,
   input wire logic cmd_data_select,
   input wire logic serial_clk,
   input wire logic write_data_pin,
   input wire logic backlight_enable,
   output logic readback_pin,
   output logic readback_oe_n,
   output logic backlight_on,
   output sdw_byte_t rx_byte,
   output sdw_pix_t pix_wr,
   output logic [7:0] scan_mode,
   output sdw_win_t window
);
   logic [`SDW_PINS-1:0] pin_s;
   logic cs_s;
   logic dc_s;
   logic sck_s;
   logic sdi_s;
   logic sck_prev_r;
   logic sck_rise;
   logic [2:0] bit_cnt_r;
   logic [2:0] bit_cnt_nxt;
   logic [7:0] shreg_r;
   logic [7:0] shreg_nxt;
   sdw_byte_t byte_r;
   sdw_byte_t byte_nxt;
   sdw_state_t state_r;
   sdw_state_t state_nxt;
   logic [1:0] param_idx_r;
   logic [1:0] param_idx_nxt;
   logic [7:0] hi_r;
   logic [7:0] hi_nxt;
   logic half_r;
   logic half_nxt;
   sdw_win_t win_r;
   sdw_win_t win_nxt;
   logic [7:0] scan_r;
   logic [7:0] scan_nxt;
   sdw_pix_t pix_r;
   sdw_pix_t pix_nxt;
   logic cur_load;
   logic cur_step;
   logic [8:0] cur_col;
   logic [8:0] cur_row;
   logic [8:0] param_val;

   // Keeps window edges inside the pixel array.
   function automatic logic [8:0] clamp(input logic [8:0] v, input logic [8:0] max);
      return (v > max) ? max : v;
   endfunction

   sdw_sync #(
      .W(`SDW_PINS),
      .RST(`SDW_PIN_RST)
   ) u_sync (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .pin_in({backlight_enable, write_data_pin, serial_clk, cmd_data_select,
               chip_select_low}),
      .level(pin_s)
   );

   assign cs_s = pin_s[`SDW_PIN_CS];
   assign dc_s = pin_s[`SDW_PIN_DC];
   assign sck_s = pin_s[`SDW_PIN_SCK];
   assign sdi_s = pin_s[`SDW_PIN_SDI];
   // sampling on the rising, first edge from a low idle clock.
   assign sck_rise = sck_s & ~sck_prev_r;

   always_comb begin
      bit_cnt_nxt = bit_cnt_r;
      shreg_nxt = shreg_r;
      byte_nxt = byte_r;
      byte_nxt.valid = 1'b0;
      if (cs_s) begin
         bit_cnt_nxt = 3'h0;
      end else if (sck_rise) begin
         // one bit taken per rising edge.
         // new bits enter at the bottom, so the first lands on top.
         shreg_nxt = {shreg_r[6:0], sdi_s};
         bit_cnt_nxt = bit_cnt_r + 3'h1;
         if (bit_cnt_r == `SDW_LAST_BIT) begin
            byte_nxt.valid = 1'b1;
            // byte tagged by the select level at its last bit.
            byte_nxt.is_data = dc_s;
            byte_nxt.data = {shreg_r[6:0], sdi_s};
         end
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         sck_prev_r <= 1'b0;
         bit_cnt_r <= 3'h0;
         shreg_r <= 8'h00;
         byte_r <= '0;
      end else begin
         sck_prev_r <= sck_s;
         bit_cnt_r <= bit_cnt_nxt;
         shreg_r <= shreg_nxt;
         byte_r <= byte_nxt;
      end
   end

   // High address byte is held in hi_r; only its low bit matters for nine-bit edges.
   assign param_val = {hi_r[0], byte_r.data};

   always_comb begin
      state_nxt = state_r;
      param_idx_nxt = param_idx_r;
      hi_nxt = hi_r;
      half_nxt = half_r;
      win_nxt = win_r;
      scan_nxt = scan_r;
      pix_nxt = pix_r;
      pix_nxt.valid = 1'b0;
      cur_load = 1'b0;
      cur_step = 1'b0;
      if (byte_r.valid && !byte_r.is_data) begin
         param_idx_nxt = 2'h0;
         half_nxt = 1'b0;
         unique case (byte_r.data)
            `SDW_CMD_COL_SET: state_nxt = SDW_ST_COL;
            `SDW_CMD_ROW_SET: state_nxt = SDW_ST_ROW;
            `SDW_CMD_SCAN: state_nxt = SDW_ST_SCAN;
            `SDW_CMD_MEM_WR: begin
               state_nxt = SDW_ST_PIX;
               cur_load = 1'b1;
            end
            default: state_nxt = SDW_ST_IDLE;
         endcase
      end else if (byte_r.valid) begin
         unique case (state_r)
            SDW_ST_IDLE: begin
            end
            SDW_ST_COL, SDW_ST_ROW: begin
               param_idx_nxt = param_idx_r + 2'h1;
               if (!param_idx_r[0]) begin
                  hi_nxt = byte_r.data;
               end else if (state_r == SDW_ST_COL) begin
                  // column edges limited to the array width.
                  if (param_idx_r[1]) begin
                     win_nxt.col_end = clamp(param_val, `SDW_COL_MAX);
                  end else begin
                     win_nxt.col_start = clamp(param_val, `SDW_COL_MAX);
                  end
               end else begin
                  // row edges limited to the array height.
                  if (param_idx_r[1]) begin
                     win_nxt.row_end = clamp(param_val, `SDW_ROW_MAX);
                  end else begin
                     win_nxt.row_start = clamp(param_val, `SDW_ROW_MAX);
                  end
               end
               if (param_idx_r == `SDW_PARAM_LAST) begin
                  state_nxt = SDW_ST_IDLE;
               end
            end
            SDW_ST_SCAN: begin
               scan_nxt = byte_r.data;
               state_nxt = SDW_ST_IDLE;
            end
            SDW_ST_PIX: begin
               // two bytes, high first, form one 5-6-5 colour.
               if (!half_r) begin
                  hi_nxt = byte_r.data;
                  half_nxt = 1'b1;
               end else begin
                  pix_nxt.valid = 1'b1;
                  pix_nxt.col = cur_col;
                  pix_nxt.row = cur_row;
                  pix_nxt.color = {hi_r, byte_r.data};
                  half_nxt = 1'b0;
                  cur_step = 1'b1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= SDW_ST_IDLE;
         param_idx_r <= 2'h0;
         hi_r <= 8'h00;
         half_r <= 1'b0;
         win_r <= {9'h000, `SDW_COL_MAX, 9'h000, `SDW_ROW_MAX};
         scan_r <= `SDW_SCAN_RST;
         pix_r <= '0;
      end else begin
         state_r <= state_nxt;
         param_idx_r <= param_idx_nxt;
         hi_r <= hi_nxt;
         half_r <= half_nxt;
         win_r <= win_nxt;
         scan_r <= scan_nxt;
         pix_r <= pix_nxt;
      end
   end

   sdw_pixel_addr u_addr (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .win(win_r),
      .col_dec(scan_r[`SDW_SCAN_COL_DEC]),
      .row_dec(scan_r[`SDW_SCAN_ROW_DEC]),
      .load(cur_load),
      .step(cur_step),
      .col(cur_col),
      .row(cur_row)
   );

   // The port only accepts writes, so the read-back line is never driven.
   assign readback_pin = 1'b0;
   assign readback_oe_n = 1'b1;
   // backlight follows the filtered enable level.
   assign backlight_on = pin_s[`SDW_PIN_BL];
   assign rx_byte = byte_r;
   assign pix_wr = pix_r;
   assign scan_mode = scan_r;
   assign window = win_r;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!arst_n);

   cs_gate_a: assert property (cs_s |=> bit_cnt_r == 3'h0 && !byte_r.valid)
      else $error("byte activity while deselected");

   dc_tag_a: assert property (byte_r.valid |-> byte_r.is_data == $past(dc_s))
      else $error("byte kind does not match select level");

   one_bit_a: assert property (sck_rise && !cs_s |=>
      bit_cnt_r == $past(bit_cnt_r) + 3'h1)
      else $error("bit count did not advance by one");

   byte_len_a: assert property (byte_r.valid |->
      $past(bit_cnt_r) == `SDW_LAST_BIT && bit_cnt_r == 3'h0)
      else $error("byte not eight bits long");

   msb_first_a: assert property (byte_r.valid |->
      byte_r.data == {$past(shreg_r[6:0]), $past(sdi_s)})
      else $error("byte bit order wrong");

   rise_only_a: assert property (!sck_rise |=> $stable(shreg_r))
      else $error("shift outside a rising edge");

   pix_pack_a: assert property (pix_r.valid |->
      pix_r.color == {$past(hi_r), $past(byte_r.data)} && $past(byte_r.is_data))
      else $error("pixel colour not packed from two data bytes");

   col_step_a: assert property (cur_step && !scan_r[`SDW_SCAN_COL_DEC] &&
      cur_col < win_r.col_end |=> cur_col == $past(cur_col) + 9'h001)
      else $error("column did not step forward");

   pix_range_a: assert property (pix_r.valid |->
      pix_r.col <= `SDW_COL_MAX && pix_r.row <= `SDW_ROW_MAX)
      else $error("pixel outside the array");

   backlight_a: assert property ($rose(backlight_enable) ##1 backlight_enable [*4]
      |-> backlight_on)
      else $error("backlight did not follow enable");

   cmd_no_pix_a: assert property (byte_r.valid && !byte_r.is_data |=> !pix_r.valid)
      else $error("command byte produced a pixel");

   col_back_a: assert property (cur_step && scan_r[`SDW_SCAN_COL_DEC] &&
      cur_col > win_r.col_start |=> cur_col == $past(cur_col) - 9'h001)
      else $error("column did not step backward");

   win_clamp_a: assert property (win_r.col_end <= `SDW_COL_MAX &&
      win_r.row_end <= `SDW_ROW_MAX)
      else $error("window edge outside the array");

   byte_seen_c: cover property (byte_r.valid && !byte_r.is_data);
   pixel_seen_c: cover property (pix_r.valid ##[1:100] pix_r.valid);
   scan_set_c: cover property (state_r == SDW_ST_SCAN && byte_r.valid && byte_r.is_data);
   row_wrap_c: cover property (cur_step ##1 cur_row != $past(cur_row));
endmodule
`default_nettype wire

// file: sdw_defines.svh
// Constants of the serial display write port.
`ifndef SDW_DEFINES_SVH
`define SDW_DEFINES_SVH
`define SDW_COLS 240
`define SDW_ROWS 320
`define SDW_GMEM_BYTES 172800
`define SDW_COL_MAX 9'h0ef
`define SDW_ROW_MAX 9'h13f
`define SDW_LAST_BIT 3'h7
`define SDW_PARAM_LAST 2'h3
`define SDW_CMD_COL_SET 8'h10
`define SDW_CMD_ROW_SET 8'h11
`define SDW_CMD_MEM_WR 8'h12
`define SDW_CMD_SCAN 8'h13
`define SDW_SCAN_COL_DEC 0
`define SDW_SCAN_ROW_DEC 1
`define SDW_SCAN_RST 8'h00
`define SDW_PINS 5
`define SDW_PIN_CS 0
`define SDW_PIN_DC 1
`define SDW_PIN_SCK 2
`define SDW_PIN_SDI 3
`define SDW_PIN_BL 4
`define SDW_PIN_RST 5'h01
`endif

// file: sdw_pkg.sv
// Types shared by the serial display write port.
`default_nettype none
package sdw_pkg;
   typedef struct packed {
      logic valid;
      logic is_data;
      logic [7:0] data;
   } sdw_byte_t;

   typedef struct packed {
      logic [8:0] col_start;
      logic [8:0] col_end;
      logic [8:0] row_start;
      logic [8:0] row_end;
   } sdw_win_t;

   typedef struct packed {
      logic [4:0] red;
      logic [5:0] green;
      logic [4:0] blue;
   } sdw_rgb_t;

   typedef struct packed {
      logic valid;
      logic [8:0] col;
      logic [8:0] row;
      sdw_rgb_t color;
   } sdw_pix_t;

   typedef enum logic [2:0] {
      SDW_ST_IDLE = 3'b000,
      SDW_ST_COL = 3'b001,
      SDW_ST_ROW = 3'b010,
      SDW_ST_SCAN = 3'b011,
      SDW_ST_PIX = 3'b100
   } sdw_state_t;
endpackage
`default_nettype wire

// file: sdw_sync.sv
// Three-stage pin synchroniser with an agreement filter.
`default_nettype none
module sdw_sync
   import sdw_pkg::*;
#(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] level
);
   logic [W-1:0] ff1_r;
   logic [W-1:0] ff2_r;
   logic [W-1:0] ff3_r;
   logic [W-1:0] level_r;
   logic [W-1:0] level_nxt;

   // A bit changes only once the second and third stages agree.
   always_comb begin
      level_nxt = level_r;
      for (int i = 0; i < W; i++) begin
         if (ff2_r[i] == ff3_r[i]) begin
            level_nxt[i] = ff3_r[i];
         end
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ff1_r <= RST;
         ff2_r <= RST;
         ff3_r <= RST;
         level_r <= RST;
      end else begin
         ff1_r <= pin_in;
         ff2_r <= ff1_r;
         ff3_r <= ff2_r;
         level_r <= level_nxt;
      end
   end

   assign level = level_r;
endmodule
`default_nettype wire

// file: sdw_pixel_addr.sv
// Pixel cursor that walks the address window in scan order.
`default_nettype none
module sdw_pixel_addr
   import sdw_pkg::*;
(
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire sdw_win_t win,
   input wire logic col_dec,
   input wire logic row_dec,
   input wire logic load,
   input wire logic step,
   output logic [8:0] col,
   output logic [8:0] row
);
   logic [8:0] col_r;
   logic [8:0] col_nxt;
   logic [8:0] row_r;
   logic [8:0] row_nxt;
   logic [9:0] col_mv;
   logic [9:0] row_mv;

   function automatic logic [8:0] axis_first(input logic [8:0] lo, input logic [8:0] hi,
                                             input logic dec);
      return dec ? hi : lo;
   endfunction

   // Returns the wrap flag above the next position; passing the far edge wraps back.
   function automatic logic [9:0] axis_next(input logic [8:0] cur, input logic [8:0] lo,
                                            input logic [8:0] hi, input logic dec);
      logic past_end;
      past_end = dec ? (cur <= lo) : (cur >= hi);
      if (past_end) begin
         return {1'b1, axis_first(lo, hi, dec)};
      end
      return {1'b0, dec ? cur - 9'h001 : cur + 9'h001};
   endfunction

   always_comb begin
      col_mv = axis_next(col_r, win.col_start, win.col_end, col_dec);
      row_mv = axis_next(row_r, win.row_start, win.row_end, row_dec);
      col_nxt = col_r;
      row_nxt = row_r;
      if (load) begin
         col_nxt = axis_first(win.col_start, win.col_end, col_dec);
         row_nxt = axis_first(win.row_start, win.row_end, row_dec);
      end else if (step) begin
         col_nxt = col_mv[8:0];
         if (col_mv[9]) begin
            row_nxt = row_mv[8:0];
         end
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         col_r <= 9'h000;
         row_r <= 9'h000;
      end else begin
         col_r <= col_nxt;
         row_r <= row_nxt;
      end
   end

   assign col = col_r;
   assign row = row_r;
endmodule
`default_nettype wire

// file: sdw_host_model.sv
// Host model that drives the serial display bus in mode 0.
`default_nettype none
module sdw_host_model (
   input wire logic ref_clk,
   output var logic chip_select_low,
   output var logic cmd_data_select,
   output var logic serial_clk,
   output var logic write_data_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   // Half of the 48 ns link period in 4 ns system cycles.
   localparam int HALF = 6;

   initial begin
      chip_select_low = 1'b1;
      cmd_data_select = 1'b1;
      serial_clk = 1'b0;
      write_data_pin = 1'b0;
   end

   task automatic wait_neg(input int n);
      repeat (n) @(negedge ref_clk);
   endtask

   task automatic shift_bits(input logic sel_n, input logic dc, input logic [7:0] v,
                             input int n);
      int i;
      chip_select_low = sel_n;
      cmd_data_select = dc;
      for (i = 7; i > 7 - n; i--) begin
         write_data_pin = v[i];
         wait_neg(HALF);
         serial_clk = ~serial_clk;
         wait_neg(HALF);
         serial_clk = ~serial_clk;
      end
   endtask

   task automatic send_byte(input logic dc, input logic [7:0] v);
      shift_bits(1'b0, dc, v, 8);
   endtask

   // released lines show no stale value
   task automatic release_bus();
      wait_neg(HALF);
      chip_select_low = 1'b1;
      write_data_pin = ~write_data_pin;
      cmd_data_select = ~cmd_data_select;
      wait_neg(HALF);
   endtask
endmodule
`default_nettype wire

// file: tb_sdw_port.sv
// Self-checking testbench of the serial display write port.
`default_nettype none
module tb_sdw_port
   import sdw_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic ref_clk;
   logic arst_n;
   logic backlight_enable;
   wire logic chip_select_low;
   wire logic cmd_data_select;
   wire logic serial_clk;
   wire logic write_data_pin;
   logic readback_pin;
   logic readback_oe_n;
   logic backlight_on;
   sdw_byte_t rx_byte;
   sdw_pix_t pix_wr;
   logic [7:0] scan_mode;
   sdw_win_t window;
   int err_total;
   int check_count;
   sdw_byte_t rxq[$];
   sdw_pix_t pxq[$];

   sdw_port u_sdw_port (.ref_clk(ref_clk), .arst_n(arst_n),
      .chip_select_low(chip_select_low), .cmd_data_select(cmd_data_select),
      .serial_clk(serial_clk), .write_data_pin(write_data_pin),
      .backlight_enable(backlight_enable), .readback_pin(readback_pin),
      .readback_oe_n(readback_oe_n), .backlight_on(backlight_on), .rx_byte(rx_byte),
      .pix_wr(pix_wr), .scan_mode(scan_mode), .window(window));

   sdw_host_model u_sdw_host_model (.ref_clk(ref_clk),
      .chip_select_low(chip_select_low), .cmd_data_select(cmd_data_select),
      .serial_clk(serial_clk), .write_data_pin(write_data_pin));

   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   // Valid pulses are caught at the falling edge, where they have settled.
   always @(negedge ref_clk) begin
      if (rx_byte.valid === 1'b1) begin
         rxq.push_back(rx_byte);
      end
      if (pix_wr.valid === 1'b1) begin
         pxq.push_back(pix_wr);
      end
   end

   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic give_verdict();
      $display("errors=%0d checks=%0d", err_total, check_count);
      if (err_total == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Sends one byte and checks that exactly that byte was assembled.
   task automatic put(input logic dc, input logic [7:0] v);
      sdw_byte_t b;
      u_sdw_host_model.send_byte(dc, v);
      u_sdw_host_model.wait_neg(10);
      check(rxq.size(), 1);
      if (rxq.size() > 0) begin
         b = rxq.pop_front();
         check(b, {1'b1, dc, v});
      end
   endtask

   task automatic pixel(input logic [15:0] c, input logic [8:0] col, input logic [8:0] row);
      put(1'b1, c[15:8]);
      put(1'b1, c[7:0]);
      check(pxq.size(), 1);
      if (pxq.size() > 0) begin
         check(pxq.pop_front(), {1'b1, col, row, c});
      end
   endtask

   task automatic t_reset();
      check(readback_pin, 1'b0);
      check(readback_oe_n, 1'b1);
      check(scan_mode, 8'h00);
      check(window, {9'h000, 9'h0ef, 9'h000, 9'h13f});
   endtask

   task automatic t_backlight();
      check(backlight_on, 1'b0);
      backlight_enable = ~backlight_enable;
      u_sdw_host_model.wait_neg(8);
      check(backlight_on, 1'b1);
      backlight_enable = ~backlight_enable;
      u_sdw_host_model.wait_neg(8);
      check(backlight_on, 1'b0);
      backlight_enable = ~backlight_enable;
   endtask

   // Reset in mid-run, then refused traffic: unknown command, idle data, odd colour byte.
   task automatic t_mid_reset();
      u_sdw_host_model.release_bus();
      arst_n = 1'b0;
      u_sdw_host_model.wait_neg(2);
      check(scan_mode, 8'h00);
      check(window, {9'h000, 9'h0ef, 9'h000, 9'h13f});
      check(backlight_on, 1'b0);
      arst_n = 1'b1;
      u_sdw_host_model.wait_neg(6);
      check(backlight_on, 1'b1);
      put(1'b0, 8'h55);
      put(1'b1, 8'h01);
      check(scan_mode, 8'h00);
      put(1'b0, 8'h12);
      put(1'b1, 8'hab);
      put(1'b0, 8'h13);
      put(1'b1, 8'h01);
      check(pxq.size(), 0);
      check(scan_mode, 8'h01);
   endtask

   task automatic t_scan();
      put(1'b0, 8'h13);
      put(1'b1, 8'h03);
      check(scan_mode, 8'h03);
      put(1'b0, 8'h13);
      put(1'b1, 8'h00);
      check(scan_mode, 8'h00);
   endtask

   task automatic t_window();
      int i;
      logic [7:0] cb[4];
      logic [7:0] rb[4];
      cb = '{8'h00, 8'hed, 8'h01, 8'hff};
      rb = '{8'h00, 8'h02, 8'h00, 8'h03};
      put(1'b0, 8'h10);
      for (i = 0; i < 4; i++) begin
         put(1'b1, cb[i]);
      end
      put(1'b0, 8'h11);
      for (i = 0; i < 4; i++) begin
         put(1'b1, rb[i]);
      end
      check(window, {9'd237, 9'd239, 9'd2, 9'd3});
   endtask

   task automatic t_pixels_inc();
      int k;
      put(1'b0, 8'h12);
      for (k = 0; k < 4; k++) begin
         pixel(16'ha5c3 ^ 16'(k * 16'h1111), 9'(237 + k % 3), 9'(2 + k / 3));
      end
   endtask

   task automatic t_pixels_dec();
      put(1'b0, 8'h13);
      put(1'b1, 8'h03);
      put(1'b0, 8'h12);
      pixel(16'hf800, 9'd239, 9'd3);
      pixel(16'h07e0, 9'd238, 9'd3);
      pixel(16'h001f, 9'd237, 9'd3);
      pixel(16'hffff, 9'd239, 9'd2);
      put(1'b0, 8'h13);
      put(1'b1, 8'h00);
   endtask

   task automatic t_abort();
      u_sdw_host_model.release_bus();
      u_sdw_host_model.shift_bits(1'b1, 1'b0, 8'h13, 8);
      u_sdw_host_model.wait_neg(10);
      check(rxq.size(), 0);
      u_sdw_host_model.shift_bits(1'b0, 1'b0, 8'h13, 4);
      u_sdw_host_model.release_bus();
      u_sdw_host_model.wait_neg(10);
      check(rxq.size(), 0);
      put(1'b0, 8'h13);
      put(1'b1, 8'h02);
      check(scan_mode, 8'h02);
      check(readback_oe_n, 1'b1);
   endtask

   initial begin
      #100us;
      err_total++;
      give_verdict();
   end

   initial begin
      err_total = 0;
      check_count = 0;
      arst_n = 1'b0;
      backlight_enable = 1'b0;
      repeat (2) @(negedge ref_clk);
      t_reset();
      arst_n = 1'b1;
      u_sdw_host_model.wait_neg(4);
      t_backlight();
      t_scan();
      t_window();
      t_pixels_inc();
      t_pixels_dec();
      t_abort();
      t_mid_reset();
      give_verdict();
   end
endmodule
`default_nettype wire
